// file: include/dbs_pkg.sv
// package for the double-data-rate burst-of-four common-i/o sram core
// assumes one compile unit that sees this package before the core module

package dbs_pkg;

  // ---------------------------------------------------------------------
  // variant and array shape defaults
  // ---------------------------------------------------------------------
  localparam int DBS_DATA_W_DEF  = 18;   // data bus width: 8, 9, 18 or 36
  localparam int DBS_ADDR_W_DEF  = 10;   // burst address pins brought out
  localparam int DBS_BYTE_LANE_W = 9;    // one byte lane incl. parity bit
  localparam int DBS_NIB_LANE_W  = 4;    // one nibble lane, 8-bit variant
  localparam int DBS_NIB_MASK_W  = 2;    // nibble masks on 8-bit variant
  localparam int DBS_BYTE_MASK_W = 4;    // most byte masks of any variant
  localparam int DBS_BURST_LEN   = 4;    // beats per accepted command
  localparam int DBS_SYNC_STAGES = 2;    // flops in every level synchroniser
  localparam int DBS_CNT_W       = 16;   // accepted command counter width

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic       DBS_RST_LOW   = 1'b0;
  localparam logic       DBS_RST_HIGH  = 1'b1;
  localparam logic [1:0] DBS_RST_PAIR  = 2'h0;
  localparam logic [2:0] DBS_RST_TRIO  = 3'h0;
  localparam logic [15:0] DBS_RST_CNT  = 16'h0000;

  // ---------------------------------------------------------------------
  // command slot state: a slot right after an accepted command is held
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    DBS_CMD_OPEN = 2'h1,
    DBS_CMD_HELD = 2'h2
  } dbs_cmd_e;

endpackage

// file: rtl/dbs_sram_core.sv
// core of a ddr burst-of-four common-i/o sram: command pipe, write
// late-capture with lane masks, pipelined read launch and echo clocks.
// assumes the controller drives command, address and write data
// synchronous to link_clk_i; the complementary input clock is the
// falling edge of link_clk_i. system-side status runs on clk_sys_i.

`timescale 1ns/100ps
`default_nettype none

module dbs_sram_core
  import dbs_pkg::*;
#(
  parameter int DATA_W = DBS_DATA_W_DEF,
  parameter int ADDR_W = DBS_ADDR_W_DEF
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        link_clk_i,
  input  wire logic                        address_latch_strobe_n_i,
  input  wire logic                        read_select_i,
  input  wire logic [ADDR_W-1:0]           burst_address_i,
  input  wire logic [DBS_BYTE_MASK_W-1:0]  byte_write_mask_n_i,
  input  wire logic [DBS_NIB_MASK_W-1:0]   nibble_write_mask_n_i,
  input  wire logic [DATA_W-1:0]           dq_i,
  output logic      [DATA_W-1:0]           dq_o,
  output logic                             dq_oe_o,
  input  wire logic                        out_clk_i,
  input  wire logic                        out_clk_n_i,
  input  wire logic                        loop_disable_n_i,
  output logic                             return_timing_pair_o,
  output logic                             return_timing_pair_n_o,
  output logic                             out_clk_fallback_o,
  output logic                             dll_enable_o,
  output logic                             cmd_accepted_o,
  output logic      [DBS_CNT_W-1:0]        cmd_count_o
);

  // -----------------------------------------------------------------------
  // variant shape
  // -----------------------------------------------------------------------
  localparam bit NIBBLE  = (DATA_W == 8);
  localparam bit NARROW  = (DATA_W <= 9);
  localparam int LANE_W  = NIBBLE ? DBS_NIB_LANE_W : DBS_BYTE_LANE_W;
  localparam int MASK_W  = NIBBLE ? DBS_NIB_MASK_W : DATA_W / DBS_BYTE_LANE_W;
  localparam int WADDR_W = NARROW ? ADDR_W + 2 : ADDR_W;
  localparam int DEPTH   = 1 << WADDR_W;

  // widths outside the four variants have no lane layout
  if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)) begin : g_bad_w
    $error("dbs_sram_core: DATA_W must be 8, 9, 18 or 36");
  end
  if (ADDR_W < 3 || ADDR_W > 20) begin : g_bad_a
    $error("dbs_sram_core: ADDR_W must lie between 3 and 20");
  end

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // word address of one beat; wide parts wrap linearly from the low bits
  function automatic logic [WADDR_W-1:0] beat_addr(input logic [ADDR_W-1:0] base,
                                                   input logic [1:0]        beat);
    logic [ADDR_W+1:0] w;
    w = '0;
    if (NARROW) begin
      w = {base, beat};
    end else begin
      w = {2'b00, base[ADDR_W-1:2], 2'(base[1:0] + beat)};
    end
    return w[WADDR_W-1:0];
  endfunction

  // lane merge: a high mask leaves the stored lane untouched
  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                   input logic [DATA_W-1:0] new_w,
                                                   input logic [MASK_W-1:0] mask_n);
    logic [DATA_W-1:0] r;
    r = old_w;
    for (int i = 0; i < MASK_W; i++) begin
      if (!mask_n[i]) begin
        r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  // gray to binary for the command count crossing
  function automatic logic [DBS_CNT_W-1:0] gray2bin(input logic [DBS_CNT_W-1:0] g);
    logic [DBS_CNT_W-1:0] b;
    b = g;
    for (int i = DBS_CNT_W-2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // -----------------------------------------------------------------------
  // link reset: asserts at once, releases on the link clock
  // -----------------------------------------------------------------------
  logic lrst_s1_r;
  logic lrst_n_r;

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lrst_s1_r <= DBS_RST_LOW;
      lrst_n_r  <= DBS_RST_LOW;
    end else begin
      lrst_s1_r <= DBS_RST_HIGH;
      lrst_n_r  <= lrst_s1_r;
    end
  end

  // -----------------------------------------------------------------------
  // command slot decode
  // -----------------------------------------------------------------------
  dbs_cmd_e          cmd_state_r;
  dbs_cmd_e          cmd_state_nxt;
  wire logic         accept_w;
  wire logic         rd_acc_w;
  wire logic         wr_acc_w;
  wire logic [MASK_W-1:0] mask_n_w;

  // a held slot ignores the pins; strobe high accepts nothing
  assign accept_w = (cmd_state_r == DBS_CMD_OPEN) && !address_latch_strobe_n_i;
  assign rd_acc_w = accept_w && read_select_i;
  assign wr_acc_w = accept_w && !read_select_i;

  if (NIBBLE) begin : g_nib
    assign mask_n_w = nibble_write_mask_n_i;
  end else begin : g_byte
    assign mask_n_w = byte_write_mask_n_i[MASK_W-1:0];
  end

  // the slot after any accepted command is held, which is what makes the
  // two-cycle command spacing safe even if the controller breaks it
  always_comb begin
    case (cmd_state_r)
      DBS_CMD_OPEN: cmd_state_nxt = accept_w ? DBS_CMD_HELD : DBS_CMD_OPEN;
      DBS_CMD_HELD: cmd_state_nxt = DBS_CMD_OPEN;
      default:      cmd_state_nxt = DBS_CMD_OPEN;
    endcase
  end

  // -----------------------------------------------------------------------
  // true-edge pipeline: command stages, write capture, read fetch
  // -----------------------------------------------------------------------
  logic [DATA_W-1:0] mem_r [0:DEPTH-1];
  logic              rd_p1_r, rd_p2_r, rd_p3_r;
  logic              wr_p1_r, wr_p2_r, wr_p3_r;
  logic [ADDR_W-1:0] rd_a_r, wr_a1_r, wr_a2_r, wr_a3_r;
  logic [DATA_W-1:0] rbuf_r [0:DBS_BURST_LEN-1];
  logic [DATA_W-1:0] wb0_r, wb2_r, wb1_r, wb3_r;
  logic [MASK_W-1:0] wm0_r, wm2_r, wm1_r, wm3_r;
  logic [DBS_CNT_W-1:0] lgray_r;
  wire logic [DBS_CNT_W-1:0] lcnt_inc_w;
  // accept count kept in gray so the status side never sees a torn word
  assign lcnt_inc_w = gray2bin(lgray_r) + DBS_CNT_W'(1);

  always_ff @(posedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      cmd_state_r <= DBS_CMD_OPEN;
      {rd_p1_r, rd_p2_r, rd_p3_r} <= DBS_RST_TRIO;
      {wr_p1_r, wr_p2_r, wr_p3_r} <= DBS_RST_TRIO;
      lgray_r     <= DBS_RST_CNT;
    end else begin
      cmd_state_r <= cmd_state_nxt;
      rd_p1_r     <= rd_acc_w;
      rd_p2_r     <= rd_p1_r;
      rd_p3_r     <= rd_p2_r;
      wr_p1_r     <= wr_acc_w;
      wr_p2_r     <= wr_p1_r;
      wr_p3_r     <= wr_p2_r;
      lgray_r     <= accept_w ? (lcnt_inc_w ^ (lcnt_inc_w >> 1)) : lgray_r;
    end
  end

  // addresses and beat storage carry no reset; stage flags qualify them
  always_ff @(posedge link_clk_i) begin
    if (accept_w) begin
      rd_a_r  <= burst_address_i;
      wr_a1_r <= burst_address_i;
    end
    wr_a2_r <= wr_a1_r;
    wr_a3_r <= wr_a2_r;
    if (wr_p1_r) begin
      wb0_r <= dq_i;
      wm0_r <= mask_n_w;
    end
    if (wr_p2_r) begin
      wb2_r <= dq_i;
      wm2_r <= mask_n_w;
    end
  end

  // read fetch one edge after the command; reads see the array before any
  // commit on the same edge, so a read right behind a write may be stale
  always_ff @(posedge link_clk_i) begin
    if (rd_p1_r) begin
      for (int b = 0; b < DBS_BURST_LEN; b++) begin
        rbuf_r[b] <= mem_r[beat_addr(rd_a_r, 2'(b))];
      end
    end
  end

  // commit: beats 0/1 at the third edge, beats 2/3 at the fourth; the
  // two-cycle spacing means the two commit slots never overlap
  always_ff @(posedge link_clk_i) begin
    if (wr_p2_r) begin
      mem_r[beat_addr(wr_a2_r, 2'd0)] <= lane_merge(mem_r[beat_addr(wr_a2_r, 2'd0)],
                                                    wb0_r, wm0_r);
      mem_r[beat_addr(wr_a2_r, 2'd1)] <= lane_merge(mem_r[beat_addr(wr_a2_r, 2'd1)],
                                                    wb1_r, wm1_r);
    end else if (wr_p3_r) begin
      mem_r[beat_addr(wr_a3_r, 2'd2)] <= lane_merge(mem_r[beat_addr(wr_a3_r, 2'd2)],
                                                    wb2_r, wm2_r);
      mem_r[beat_addr(wr_a3_r, 2'd3)] <= lane_merge(mem_r[beat_addr(wr_a3_r, 2'd3)],
                                                    wb3_r, wm3_r);
    end
  end

  // -----------------------------------------------------------------------
  // complementary-edge write capture
  // -----------------------------------------------------------------------
  always_ff @(negedge link_clk_i) begin
    if (wr_p2_r) begin
      wb1_r <= dq_i;
      wm1_r <= mask_n_w;
    end
    if (wr_p3_r) begin
      wb3_r <= dq_i;
      wm3_r <= mask_n_w;
    end
  end

  // -----------------------------------------------------------------------
  // read launch, both edges, with echo clocks
  // -----------------------------------------------------------------------
  logic [DATA_W-1:0] dqp_r, dqn_r;
  logic              oep_r, oen_r;
  wire logic         launch_p_w;
  wire logic         launch_n_w;

  assign launch_p_w = rd_p2_r || rd_p3_r;
  assign launch_n_w = rd_p2_r || rd_p3_r;

  // true-edge half: beats 2 and 4
  always_ff @(posedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      dqp_r                <= '0;
      oep_r                <= DBS_RST_LOW;
      return_timing_pair_o <= DBS_RST_LOW;
    end else begin
      dqp_r                <= rd_p2_r ? rbuf_r[1] : rbuf_r[3];
      oep_r                <= launch_p_w;
      return_timing_pair_o <= return_timing_pair_o ^ launch_p_w;
    end
  end

  // complementary-edge half: beats 1 and 3
  always_ff @(negedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      dqn_r                  <= '0;
      oen_r                  <= DBS_RST_LOW;
      return_timing_pair_n_o <= DBS_RST_LOW;
    end else begin
      dqn_r                  <= rd_p2_r ? rbuf_r[0] : rbuf_r[2];
      oen_r                  <= launch_n_w;
      return_timing_pair_n_o <= return_timing_pair_n_o ^ launch_n_w;
    end
  end

  // ddr output select: the clock level picks the half that fired last
  assign dq_o    = link_clk_i ? dqp_r : dqn_r;
  assign dq_oe_o = link_clk_i ? oep_r : oen_r;

  // -----------------------------------------------------------------------
  // output-clock fallback detect on the link side
  // -----------------------------------------------------------------------
  // both output clocks are async pins here; a free-running pair is never
  // seen high together at the true edge, only a pair tied high is
  logic [1:0] oclk_s1_r, oclk_s2_r;
  logic       oclk_hi_d_r;
  logic       fallback_r;

  always_ff @(posedge link_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      oclk_s1_r   <= DBS_RST_PAIR;
      oclk_s2_r   <= DBS_RST_PAIR;
      oclk_hi_d_r <= DBS_RST_LOW;
      fallback_r  <= DBS_RST_LOW;
    end else begin
      oclk_s1_r   <= {out_clk_i, out_clk_n_i};
      oclk_s2_r   <= oclk_s1_r;
      oclk_hi_d_r <= &oclk_s2_r;
      fallback_r  <= (&oclk_s2_r) && oclk_hi_d_r;
    end
  end

  // -----------------------------------------------------------------------
  // system-side status: delay loop, fallback, command events
  // -----------------------------------------------------------------------
  logic                 dll_s1_r, dll_s2_r;
  logic                 fb_s1_r, fb_s2_r;
  logic [DBS_CNT_W-1:0] cnt_s1_r, cnt_s2_r;
  wire logic [DBS_CNT_W-1:0] sys_cnt_w;
  wire logic                 cnt_behind_w;

  // status count steps once per cycle toward the link count: commands
  // faster than this clock are reported late, but none is lost
  assign sys_cnt_w    = gray2bin(cnt_s2_r);
  assign cnt_behind_w = (sys_cnt_w != cmd_count_o);

  // each crossing is two flops; the gray count moves one bit per command
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {dll_s1_r, dll_s2_r}           <= DBS_RST_PAIR;
      {fb_s1_r, fb_s2_r}             <= DBS_RST_PAIR;
      cnt_s1_r                       <= DBS_RST_CNT;
      cnt_s2_r                       <= DBS_RST_CNT;
      dll_enable_o                   <= DBS_RST_LOW;
      out_clk_fallback_o             <= DBS_RST_LOW;
      cmd_accepted_o                 <= DBS_RST_LOW;
      cmd_count_o                    <= DBS_RST_CNT;
    end else begin
      dll_s1_r           <= loop_disable_n_i;
      dll_s2_r           <= dll_s1_r;
      dll_enable_o       <= dll_s2_r;
      fb_s1_r            <= fallback_r;
      fb_s2_r            <= fb_s1_r;
      out_clk_fallback_o <= fb_s2_r;
      cnt_s1_r           <= lgray_r;
      cnt_s2_r           <= cnt_s1_r;
      cmd_accepted_o     <= cnt_behind_w;
      cmd_count_o        <= cmd_count_o + DBS_CNT_W'(cnt_behind_w);
    end
  end

endmodule

`default_nettype wire

// file: tb/dbs_ctrl_model.sv
// memory controller model driving the sram command and write-data pins
// assumes the bench calls cmd() and owns the gap between commands
`timescale 1ns/100ps
`default_nettype none
module dbs_ctrl_model #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 18
) (
  input  wire logic              link_clk_i,
  output logic                   address_latch_strobe_n_o,
  output logic                   read_select_o,
  output logic [ADDR_W-1:0]      burst_address_o,
  output logic [3:0]             byte_write_mask_n_o,
  output logic [DATA_W-1:0]      dq_o
);
  initial begin
    address_latch_strobe_n_o = 1'b1;
    read_select_o = 1'b0;
    burst_address_o = '0;
    byte_write_mask_n_o = 4'hF;
    dq_o = '0;
  end
  // pins move 3 ns after an edge, well clear of both sampling edges
  task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a,
                     input logic [3:0][DATA_W-1:0] d, input logic [3:0][3:0] m,
                     input logic hold);
    int b;
    @(negedge link_clk_i) #3;
    address_latch_strobe_n_o = 1'b0;
    read_select_o = rd;
    burst_address_o = a;
    // one step per half cycle: blind slot first, then the four write beats
    for (b = 0; b < 6; b++) begin
      @(link_clk_i) #3;
      if (b == 0) begin
        address_latch_strobe_n_o = !hold;
        read_select_o = 1'($urandom);
        burst_address_o = ~a;
      end
      if (b == 2) address_latch_strobe_n_o = 1'b1;
      if (!rd && b > 0 && b < 5) begin
        dq_o = d[b-1];
        byte_write_mask_n_o = m[b-1];
      end
      if (!rd && b == 5) begin
        // released lines show the inverse, never a stale copy
        dq_o = ~dq_o;
        byte_write_mask_n_o = ~byte_write_mask_n_o;
      end
      if (rd && b == 2) break;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/dbs_sram_core_asserts.sv
// checker for the sram core: command pipe, read drive, echo clocks, status
// assumes a bind onto dbs_sram_core; sees only that module's ports
`timescale 1ns/100ps
`default_nettype none
module dbs_sram_core_asserts
  import dbs_pkg::*;
(
  input wire logic                 clk_sys_i,
  input wire logic                 rst_n_i,
  input wire logic                 link_clk_i,
  input wire logic                 address_latch_strobe_n_i,
  input wire logic                 read_select_i,
  input wire logic                 dq_oe_o,
  input wire logic                 out_clk_i,
  input wire logic                 out_clk_n_i,
  input wire logic                 loop_disable_n_i,
  input wire logic                 return_timing_pair_o,
  input wire logic                 return_timing_pair_n_o,
  input wire logic                 out_clk_fallback_o,
  input wire logic                 dll_enable_o,
  input wire logic                 cmd_accepted_o,
  input wire logic [DBS_CNT_W-1:0] cmd_count_o
);
  // ------------------------------------------------------------------
  // slot mirror: the rise after a taken command is blind
  // ------------------------------------------------------------------
  logic       held_r;
  logic [3:0] rd_sh_r;
  wire        acc = !address_latch_strobe_n_i && !held_r;
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_r  <= 1'b0;
      rd_sh_r <= 4'h0;
    end else begin
      held_r  <= acc;
      rd_sh_r <= {rd_sh_r[2:0], acc && read_select_i};
    end
  end
  property p_read_oe;
    @(posedge link_clk_i) disable iff (!rst_n_i)
      acc && read_select_i |-> ##2 dq_oe_o ##1 dq_oe_o;
  endproperty
  a_read_oe: assert property (p_read_oe) else $error("read burst not driven");
  property p_oe_src;
    @(posedge link_clk_i) disable iff (!rst_n_i) dq_oe_o |-> rd_sh_r[1] || rd_sh_r[2];
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("bus driven without read");
  property p_pair;
    @(posedge link_clk_i) disable iff (!rst_n_i)
      $changed(return_timing_pair_o) == (rd_sh_r[2] || rd_sh_r[3]);
  endproperty
  a_pair: assert property (p_pair) else $error("true echo out of step");
  property p_pair_n;
    @(negedge link_clk_i) disable iff (!rst_n_i)
      $changed(return_timing_pair_n_o) == (rd_sh_r[2] || rd_sh_r[3]);
  endproperty
  a_pair_n: assert property (p_pair_n) else $error("compl echo out of step");
  property p_count;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      cmd_count_o == $past(cmd_count_o) + {15'h0, cmd_accepted_o};
  endproperty
  a_count: assert property (p_count) else $error("count off its pulse");
  property p_dll_off;
    @(posedge clk_sys_i) disable iff (!rst_n_i) (!loop_disable_n_i) [*4] |-> !dll_enable_o;
  endproperty
  a_dll_off: assert property (p_dll_off) else $error("loop not disabled");
  property p_dll_on;
    @(posedge clk_sys_i) disable iff (!rst_n_i) loop_disable_n_i [*4] |-> dll_enable_o;
  endproperty
  a_dll_on: assert property (p_dll_on) else $error("loop not enabled");
  property p_fb_on;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (out_clk_i && out_clk_n_i) [*8] |-> out_clk_fallback_o;
  endproperty
  a_fb_on: assert property (p_fb_on) else $error("fallback not reported");
  c_read: cover property (@(posedge link_clk_i) acc && read_select_i);
  c_write: cover property (@(posedge link_clk_i) acc && !read_select_i);
  c_blind: cover property (@(posedge link_clk_i) held_r && !address_latch_strobe_n_i);
endmodule
bind dbs_sram_core dbs_sram_core_asserts u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
  .address_latch_strobe_n_i(address_latch_strobe_n_i), .read_select_i(read_select_i),
  .dq_oe_o(dq_oe_o), .out_clk_i(out_clk_i), .out_clk_n_i(out_clk_n_i),
  .loop_disable_n_i(loop_disable_n_i), .return_timing_pair_o(return_timing_pair_o),
  .return_timing_pair_n_o(return_timing_pair_n_o), .out_clk_fallback_o(out_clk_fallback_o),
  .dll_enable_o(dll_enable_o), .cmd_accepted_o(cmd_accepted_o), .cmd_count_o(cmd_count_o));
`default_nettype wire

// file: tb/tb.sv
// self-checking bench: random burst traffic against a memory image
// assumes dbs_pkg, the core, its checker and the controller model compiled
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dbs_pkg::*;
  localparam int AW = 4;
  localparam int DW = 18;
  logic clk_sys_i = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic oclk = 1'b0, oclk_n = 1'b1, loop_n = 1'b1;
  wire logic strb_n, rsel, oe, pr, pr_n, fb, dll, acc;
  wire logic [AW-1:0] addr;
  wire logic [3:0] bm;
  wire logic [DW-1:0] dqi, dqo;
  wire logic [DBS_CNT_W-1:0] cnt;
  logic [DW-1:0] exp_q[$];
  logic [DW-1:0] mem[16];
  int n_fail = 0, n_checks = 0, cycles = 0, n_cmd = 0;
  initial forever #25 clk_sys_i = ~clk_sys_i;
  initial begin
    #3.7;
    forever #6 link_clk = ~link_clk;
  end
  dbs_sram_core #(.DATA_W(DW), .ADDR_W(AW)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n),
    .link_clk_i(link_clk), .address_latch_strobe_n_i(strb_n), .read_select_i(rsel),
    .burst_address_i(addr), .byte_write_mask_n_i(bm), .nibble_write_mask_n_i(2'h3),
    .dq_i(dqi), .dq_o(dqo), .dq_oe_o(oe), .out_clk_i(oclk), .out_clk_n_i(oclk_n),
    .loop_disable_n_i(loop_n), .return_timing_pair_o(pr), .return_timing_pair_n_o(pr_n),
    .out_clk_fallback_o(fb), .dll_enable_o(dll), .cmd_accepted_o(acc), .cmd_count_o(cnt));
  dbs_ctrl_model #(.ADDR_W(AW), .DATA_W(DW)) ctl (.link_clk_i(link_clk),
    .address_latch_strobe_n_o(strb_n), .read_select_o(rsel), .burst_address_o(addr),
    .byte_write_mask_n_o(bm), .dq_o(dqi));
  task automatic chk_beat(input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] read beat expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_cnt(input logic [DBS_CNT_W-1:0] e, input logic [DBS_CNT_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] cmd_count_o expected %0d seen %0d", e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // image update and expected beats noted before the command goes out
  task automatic op(input logic rd, input logic [AW-1:0] a, input logic [3:0][3:0] m,
                    input logic hold);
    logic [3:0][DW-1:0] d;
    logic [AW-1:0] ix;
    for (int b = 0; b < 4; b++) begin
      d[b] = DW'($urandom);
      ix = {a[AW-1:2], a[1:0] + 2'(b)};
      if (rd) exp_q.push_back(mem[ix]);
      if (!rd && !m[b][0]) mem[ix][8:0] = d[b][8:0];
      if (!rd && !m[b][1]) mem[ix][17:9] = d[b][17:9];
    end
    n_cmd++;
    ctl.cmd(rd, a, d, m, hold);
  endtask
  // watcher: mid half-cycle, every driven beat takes the oldest note
  initial forever begin
    @(link_clk) #3;
    if (oe === 1'b1 && exp_q.size() == 0) chk_bit("dq_oe_o", 1'b0, oe);
    else if (oe === 1'b1) chk_beat(exp_q.pop_front(), dqo);
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      $display("[ERR] run length expected under 2000 seen 2000");
      final_report();
    end
  end
  initial begin
    logic rd, rd_prev;
    logic [3:0][3:0] m;
    rd_prev = 1'b0;
    void'($urandom(82));
    repeat (12) @(posedge clk_sys_i);
    @(negedge clk_sys_i) rst_n = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    for (int i = 0; i < 16; i += 4) op(1'b0, AW'(i), '0, 1'b0);
    $display("test fill done");
    for (int i = 0; i < 40; i++) begin
      rd = 1'($urandom);
      m = 16'($urandom);
      // turnaround idle before a write that follows a read
      if (rd_prev && !rd) repeat (3) @(posedge link_clk);
      op(rd, AW'($urandom), m, 1'($urandom));
      rd_prev = rd;
      repeat ($urandom_range(2)) @(posedge link_clk);
    end
    repeat (8) @(posedge link_clk);
    chk_bit("beats left", 1'b1, exp_q.size() == 0);
    $display("test traffic done");
    @(negedge clk_sys_i) loop_n = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    chk_bit("dll_enable_o", 1'b0, dll);
    chk_bit("out_clk_fallback_o", 1'b0, fb);
    loop_n = 1'b1;
    oclk = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk_bit("dll_enable_o", 1'b1, dll);
    chk_bit("out_clk_fallback_o", 1'b1, fb);
    // the status count drains its backlog at one command per cycle
    repeat (40) @(negedge clk_sys_i);
    chk_cnt(DBS_CNT_W'(n_cmd), cnt);
    $display("test status done");
    final_report();
  end
endmodule
`default_nettype wire
